//--- src/embs_pkg.sv
// package for the external memory bus sequencer
// Functional notes
// - address valid two periods before strobe falls
// - address held one period after strobe falls
// - port address lines stable whole cycle
// - program strobe low three periods on fetch
// - instruction captured before program strobe rises
// - read strobe three after latch, six long
// - write data two periods before write strobe
// - write data held two periods after strobe
// - port pins sampled at state5_phase2
// - port outputs updated end of state6_phase2
package embs_pkg;
    localparam int CLK_HZ          = 50_000_000;
    localparam int OSC_DIV         = 2;
    localparam logic [4:0] CYC_LEN = 5'h18;
    // positions in oscillator periods within a 24-period machine cycle
    localparam logic [4:0] ALE_RISE  = 5'h00;
    localparam logic [4:0] ALE_FALL  = 5'h02;
    localparam logic [4:0] ADDR_END  = 5'h03;
    localparam logic [4:0] PS_FALL   = 5'h04;
    localparam logic [4:0] PS_RISE   = 5'h07;
    localparam logic [4:0] PS_CAPT   = 5'h06;
    localparam logic [4:0] DS_FALL   = 5'h05;
    localparam logic [4:0] DS_RISE   = 5'h0b;
    localparam logic [4:0] RD_CAPT   = 5'h0a;
    localparam logic [4:0] WD_END    = 5'h0c;
    localparam logic [4:0] STATE5_PHASE2_POS  = 5'h13;
    localparam logic [4:0] STATE6_PHASE2_END  = 5'h17;
    localparam real FLASH_PULSE_US   = 300.0;
    localparam real FLASH_MIN_US     = 290.0;
    localparam real FLASH_MAX_US     = 310.0;
    localparam int FLASH_MIN_CYC     = int'(FLASH_MIN_US * real'(CLK_HZ) / 1.0e6);
    localparam int FLASH_MAX_CYC     = int'(FLASH_MAX_US * real'(CLK_HZ) / 1.0e6);
    typedef enum logic [1:0] {OP_FETCH, OP_READ, OP_WRITE, OP_IDLE} embs_op_type;
    typedef struct packed {
        embs_op_type op;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } embs_req_type;
endpackage

//--- src/embs_sequencer.sv
// external memory bus sequencer top
`timescale 1ns/1ns
module embs_sequencer
    import embs_pkg::*;
#(
    parameter int FLASH_MIN = FLASH_MIN_CYC,
    parameter int FLASH_MAX = FLASH_MAX_CYC
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire embs_req_type req,
    input  wire logic         reqValid,
    output logic              reqReady,
    output logic [7:0]        rdData,
    output logic              rdValid,
    input  wire logic [7:0]   portOut,
    input  wire logic [7:0]   portPinIn,
    output logic [7:0]        portPinOut,
    output logic [7:0]        portSample,
    output logic              addrLatch,
    output logic              program_store_strobe_n,
    output logic              readStrobe_n,
    output logic              writeStrobe_n,
    output logic [7:0]        low_addr_data_port_out,
    output logic              low_addr_data_port_oe_n,
    input  wire logic [7:0]   low_addr_data_port_in,
    output logic [7:0]        high_addr_port,
    input  wire logic         resetPin,
    input  wire logic         latchPin,
    input  wire logic         storePin,
    input  wire logic         progPulsePin,
    output logic              flashMode,
    output logic              flashProgram,
    output logic              flashPulseBad
);
    logic              divCnt;
    logic [4:0]        phase;
    logic              tick;
    embs_req_type      cur;
    logic [7:0]        busSync1;
    logic [7:0]        busSync2;
    logic [7:0]        portSync1;
    logic [7:0]        portSync2;
    logic [3:0]        pinSync1;
    logic [3:0]        pinSync2;
    logic              pulsePrev;
    logic [15:0]       pulseCnt;
    logic              cycEnd;
    logic              inAddr;
    logic              inWrData;
    logic              psActive;
    logic              dsActive;
    logic              pulseEnd;
    logic              next_addrLatch;
    logic              next_progStrobe_n;
    logic              next_readStrobe_n;
    logic              next_writeStrobe_n;
    logic [7:0]        next_lowOut;
    logic              next_lowOe_n;
    logic              sampleHit;
    logic              updateHit;
    logic              pulseInWindow;

    // 50 MHz core divided to one oscillator period tick
    assign tick     = (divCnt == 1'(OSC_DIV - 1));
    assign cycEnd   = tick && (phase == CYC_LEN - 5'h01);
    assign reqReady = cycEnd;
    assign inAddr   = (cur.op != OP_IDLE) && (phase < ADDR_END);
    assign psActive = (cur.op == OP_FETCH) && (phase >= PS_FALL) && (phase < PS_RISE);
    assign dsActive = (phase >= DS_FALL) && (phase < DS_RISE);
    assign inWrData = (cur.op == OP_WRITE) && (phase >= ADDR_END) && (phase <= WD_END);
    assign sampleHit = tick && (phase == STATE5_PHASE2_POS);
    assign updateHit = tick && (phase == STATE6_PHASE2_END);

    // levels decoded here and only registered below, so every pin edge lags its period boundary by one core clock
    assign next_addrLatch     = (cur.op != OP_IDLE) && (phase < ALE_FALL);
    assign next_progStrobe_n  = !psActive;
    assign next_readStrobe_n  = !((cur.op == OP_READ) && dsActive);
    assign next_writeStrobe_n = !((cur.op == OP_WRITE) && dsActive);
    assign next_lowOut        = inAddr ? cur.addr[7:0] : cur.wdata;
    assign next_lowOe_n       = !(inAddr || inWrData);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            divCnt <= 1'b0;
            phase  <= 5'h00;
        end else begin
            divCnt <= tick ? 1'b0 : divCnt + 1'b1;
            if (tick) begin
                phase <= cycEnd ? 5'h00 : phase + 5'h01;
            end
        end
    end

    // request latched only at cycle boundary so address ports stay put
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur <= '{op: OP_IDLE, addr: 16'h0000, wdata: 8'h00};
        end else if (cycEnd) begin
            cur <= reqValid ? req : '{op: OP_IDLE, addr: 16'h0000, wdata: 8'h00};
        end
    end

    // strobes registered from the period counter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            addrLatch               <= 1'b0;
            program_store_strobe_n  <= 1'b1;
            readStrobe_n            <= 1'b1;
            writeStrobe_n           <= 1'b1;
            low_addr_data_port_out  <= 8'h00;
            low_addr_data_port_oe_n <= 1'b1;
            high_addr_port          <= 8'h00;
        end else begin
            addrLatch               <= next_addrLatch;
            program_store_strobe_n  <= next_progStrobe_n;
            readStrobe_n            <= next_readStrobe_n;
            writeStrobe_n           <= next_writeStrobe_n;
            low_addr_data_port_out  <= next_lowOut;
            low_addr_data_port_oe_n <= next_lowOe_n;
            high_addr_port          <= cur.addr[15:8];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busSync1  <= 8'h00;
            busSync2  <= 8'h00;
            portSync1 <= 8'h00;
            portSync2 <= 8'h00;
            pinSync1  <= 4'h0;
            pinSync2  <= 4'h0;
        end else begin
            busSync1  <= low_addr_data_port_in;
            busSync2  <= busSync1;
            portSync1 <= portPinIn;
            portSync2 <= portSync1;
            pinSync1  <= {resetPin, latchPin, storePin, progPulsePin};
            pinSync2  <= pinSync1;
        end
    end

    // sampling late in the strobe window covers the two-stage synchroniser delay
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
        end else begin
            rdValid <= 1'b0;
            if (tick && (((cur.op == OP_FETCH) && (phase == PS_CAPT)) ||
                         ((cur.op == OP_READ) && (phase == RD_CAPT)))) begin
                rdData  <= busSync2;
                rdValid <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            portSample <= 8'h00;
            portPinOut <= 8'hff;
        end else begin
            if (sampleHit) begin
                portSample <= portSync2;
            end
            if (updateHit) begin
                portPinOut <= portOut;
            end
        end
    end

    // flash mode only while pins hold the entry levels
    assign flashMode = pinSync2[3] && !pinSync2[2] && pinSync2[1];
    assign pulseEnd  = pulsePrev && !pinSync2[0];
    assign pulseInWindow = (32'(pulseCnt) >= FLASH_MIN) && (32'(pulseCnt) <= FLASH_MAX);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulsePrev     <= 1'b0;
            pulseCnt      <= 16'h0000;
            flashProgram  <= 1'b0;
            flashPulseBad <= 1'b0;
        end else begin
            pulsePrev    <= pinSync2[0] && flashMode;
            flashProgram <= 1'b0;
            if (pinSync2[0] && flashMode) begin
                pulseCnt <= (pulseCnt == 16'hffff) ? pulseCnt : pulseCnt + 16'h0001;
            end else begin
                pulseCnt <= 16'h0000;
            end
            if (pulseEnd) begin
                // pulse outside window is flagged, not written
                flashProgram  <= pulseInWindow;
                flashPulseBad <= !pulseInWindow;
            end
        end
    end

    AST_ALE_WIDTH: assert property (@(posedge core_clk) disable iff (rst)
        $rose(addrLatch) |-> addrLatch [*4] ##1 !addrLatch)
        else $error("latch strobe width wrong");
    AST_ADDR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        $fell(addrLatch) |-> !low_addr_data_port_oe_n [*2])
        else $error("address not held after latch fall");
    AST_PS_WIDTH: assert property (@(posedge core_clk) disable iff (rst)
        $fell(program_store_strobe_n) |-> !program_store_strobe_n [*6] ##1 program_store_strobe_n)
        else $error("program strobe width wrong");
    AST_PS_AFTER_ALE: assert property (@(posedge core_clk) disable iff (rst)
        $fell(addrLatch) |-> program_store_strobe_n [*4])
        else $error("program strobe too early");
    AST_CAPT_BEFORE_PS: assert property (@(posedge core_clk) disable iff (rst)
        $rose(program_store_strobe_n) |-> $past(rdValid))
        else $error("fetch not captured before strobe rise");
    AST_RD_POS: assert property (@(posedge core_clk) disable iff (rst)
        $fell(readStrobe_n) |-> $past(addrLatch, 7) && !$past(addrLatch, 6))
        else $error("read strobe misplaced");
    AST_RD_WIDTH: assert property (@(posedge core_clk) disable iff (rst)
        $fell(readStrobe_n) |-> ##11 !readStrobe_n ##1 readStrobe_n)
        else $error("read strobe width wrong");
    AST_WR_SETUP: assert property (@(posedge core_clk) disable iff (rst)
        $fell(writeStrobe_n) |-> !$past(low_addr_data_port_oe_n, 2))
        else $error("write data setup short");
    AST_WR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        $rose(writeStrobe_n) |-> !low_addr_data_port_oe_n [*2])
        else $error("write data hold short");
    AST_HIGH_STABLE: assert property (@(posedge core_clk) disable iff (rst)
        !(tick && phase == CYC_LEN - 5'h01) && !$past(cycEnd) |-> ##1 $stable(high_addr_port))
        else $error("high address changed mid cycle");
    AST_FLASH_MODE: assert property (@(posedge core_clk) disable iff (rst)
        flashProgram |-> $past(flashMode, 2))
        else $error("program outside flash mode");

    // bus cycle shape
    AST_ADDR_SETUP: assert property (@(posedge core_clk) disable iff (rst)
        $fell(addrLatch) |-> !$past(low_addr_data_port_oe_n, 3) && ($past(low_addr_data_port_out, 3) == cur.addr[7:0]))
        else $error("address setup short");
    AST_ADDR_STEADY: assert property (@(posedge core_clk) disable iff (rst)
        $fell(addrLatch) |-> (low_addr_data_port_out == cur.addr[7:0]) [*2])
        else $error("address changed after latch fall");
    AST_ALE_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        addrLatch |-> (cur.op != OP_IDLE))
        else $error("latch strobe in idle cycle");
    AST_PS_FETCH_ONLY: assert property (@(posedge core_clk) disable iff (rst)
        !program_store_strobe_n |-> (cur.op == OP_FETCH))
        else $error("program strobe outside fetch");
    AST_STROBE_EXCL: assert property (@(posedge core_clk) disable iff (rst)
        $onehot0({!program_store_strobe_n, !readStrobe_n, !writeStrobe_n}))
        else $error("two strobes low together");
    AST_RD_BUS_FREE: assert property (@(posedge core_clk) disable iff (rst)
        !readStrobe_n |-> low_addr_data_port_oe_n)
        else $error("bus driven during read");
    AST_WR_POS: assert property (@(posedge core_clk) disable iff (rst)
        $fell(writeStrobe_n) |-> $past(addrLatch, 7) && !$past(addrLatch, 6))
        else $error("write strobe misplaced");
    AST_WR_WIDTH: assert property (@(posedge core_clk) disable iff (rst)
        $fell(writeStrobe_n) |-> ##11 !writeStrobe_n ##1 writeStrobe_n)
        else $error("write strobe width wrong");
    AST_WR_DATA: assert property (@(posedge core_clk) disable iff (rst)
        !writeStrobe_n |-> !low_addr_data_port_oe_n && (low_addr_data_port_out == cur.wdata))
        else $error("write data wrong under strobe");
    AST_WR_DATA_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        $rose(writeStrobe_n) |-> (low_addr_data_port_out == cur.wdata) [*2])
        else $error("write data changed after strobe");
    AST_HIGH_VALUE: assert property (@(posedge core_clk) disable iff (rst)
        rdValid |-> (high_addr_port == cur.addr[15:8]))
        else $error("high address wrong at capture");
    AST_REQ_TAKE: assert property (@(posedge core_clk) disable iff (rst)
        cycEnd && reqValid |=> (cur == $past(req)))
        else $error("request not taken at cycle end");

    // capture, port and flash timing
    AST_REQ_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        cycEnd && !reqValid |=> (cur.op == OP_IDLE))
        else $error("cycle not idle without request");
    AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        (cur.op == OP_IDLE) && (phase != 5'h00) |-> !addrLatch && low_addr_data_port_oe_n)
        else $error("bus active in idle cycle");
    AST_FETCH_CAPT: assert property (@(posedge core_clk) disable iff (rst)
        rdValid && (cur.op == OP_FETCH) |-> !program_store_strobe_n)
        else $error("fetch captured outside strobe");
    AST_RD_CAPT: assert property (@(posedge core_clk) disable iff (rst)
        rdValid && (cur.op == OP_READ) |-> !readStrobe_n)
        else $error("read captured outside strobe");
    AST_PORT_SAMPLE: assert property (@(posedge core_clk) disable iff (rst)
        sampleHit |=> (portSample == $past(portSync2)))
        else $error("port pins not sampled");
    AST_PORT_SAMPLE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !sampleHit |=> $stable(portSample))
        else $error("port sample changed off its slot");
    AST_PORT_UPDATE: assert property (@(posedge core_clk) disable iff (rst)
        updateHit |=> (portPinOut == $past(portOut)))
        else $error("port output not updated");
    AST_PORT_UPDATE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !updateHit |=> $stable(portPinOut))
        else $error("port output changed off its slot");
    AST_TICK_PERIOD: assert property (@(posedge core_clk) disable iff (rst)
        tick |=> !tick)
        else $error("period tick too dense");
    AST_PHASE_RANGE: assert property (@(posedge core_clk) disable iff (rst)
        phase < CYC_LEN)
        else $error("period counter out of range");
    AST_PROG_PULSE: assert property (@(posedge core_clk) disable iff (rst)
        $rose(flashProgram) |=> !flashProgram)
        else $error("program pulse longer than one cycle");

endmodule // embs_sequencer

//--- bench/embs_mem_model.sv
// external memory and address latch model for the bus sequencer
`timescale 1ns/1ns
module embs_mem_model (
    input  wire logic       core_clk,
    input  wire logic       slow,
    input  wire logic       addrLatch,
    input  wire logic       psN,
    input  wire logic       rdN,
    input  wire logic       wrN,
    input  wire logic [7:0] busOut,
    input  wire logic       busOe_n,
    output logic [7:0]      busIn
);
    logic [7:0] mem [256];
    logic [7:0] latchAddr;
    logic [7:0] last;
    logic [3:0] age;
    logic [3:0] delay;
    logic       memDrive;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    always @(negedge addrLatch) latchAddr = busOut;
    always @(posedge wrN) mem[latchAddr] = busOut;
    // slow answers use most of the access window the device allows
    assign delay = slow ? (psN ? 4'h6 : 4'h2) : 4'h1;
    assign memDrive = (!psN || !rdN) && age >= delay;
    // a floating bus shows the inverse of the last value, never a held copy
    assign busIn = !busOe_n ? busOut : memDrive ? mem[latchAddr] : ~last;
    always @(posedge core_clk) begin
        last <= busIn;
        age <= (!psN || !rdN) ? ((age == 4'hf) ? age : age + 4'h1) : 4'h0;
    end
endmodule // embs_mem_model

//--- bench/tb.sv
// self-checking testbench for the bus sequencer
`timescale 1ns/1ns
module tb;
    import embs_pkg::*;
    logic         core_clk, rst, reqValid, reqReady, rdValid, addrLatch, psN, rdN, wrN, oeN, slow;
    logic         resetPin, latchPin, storePin, progPulsePin, flashMode, flashProgram, flashPulseBad;
    logic [7:0]   rdData, portOut, portPinIn, portPinOut, portSample, busOut, busIn, high_addr_port;
    logic [7:0]   gotData, gotHigh;
    embs_req_type req;
    int           err_count, comparisons, cycles, psLen, rdLen, wrLen, aleLen, psLast, rdLast, wrLast, aleLast, progs;
    embs_sequencer #(.FLASH_MIN(20), .FLASH_MAX(30)) dut (.core_clk, .rst, .req, .reqValid, .reqReady, .rdData,
        .rdValid, .portOut, .portPinIn, .portPinOut, .portSample, .addrLatch, .program_store_strobe_n(psN),
        .readStrobe_n(rdN), .writeStrobe_n(wrN), .low_addr_data_port_out(busOut), .low_addr_data_port_oe_n(oeN),
        .low_addr_data_port_in(busIn), .high_addr_port, .resetPin, .latchPin, .storePin, .progPulsePin,
        .flashMode, .flashProgram, .flashPulseBad);
    embs_mem_model mem (.core_clk, .slow, .addrLatch, .psN, .rdN, .wrN, .busOut, .busOe_n(oeN), .busIn);
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // strobe widths are measured in core clocks, two per oscillator period
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        psLen <= psN ? 0 : psLen + 1;
        rdLen <= rdN ? 0 : rdLen + 1;
        wrLen <= wrN ? 0 : wrLen + 1;
        aleLen <= addrLatch ? aleLen + 1 : 0;
        if (psN && psLen > 0) psLast <= psLen;
        if (rdN && rdLen > 0) rdLast <= rdLen;
        if (wrN && wrLen > 0) wrLast <= wrLen;
        if (!addrLatch && aleLen > 0) aleLast <= aleLen;
        if (rdValid) gotData <= rdData;
        if (rdValid) gotHigh <= high_addr_port;
        if (flashProgram) progs <= progs + 1;
        if (cycles == 6000) begin
            err_count++;
            report_and_stop();
        end
    end
    // drops the request once taken; a following call still lands in the very next machine cycle
    task automatic do_op(input embs_op_type op, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{op: op, addr: a, wdata: d};
        reqValid <= 1'b1;
        @(negedge core_clk);
        while (reqReady !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        reqValid <= 1'b0;
        repeat (45) @(negedge core_clk);
    endtask
    task automatic t_fetch();
        slow <= 1'b1;
        do_op(OP_FETCH, 16'h12a5, 8'h00);
        check(gotData, 8'hff);
        check(psLast, 6);
        check(aleLast, 4);
        check(mem.latchAddr, 8'ha5);
        check(gotHigh, 8'h12);
    endtask
    task automatic t_read_write();
        do_op(OP_READ, 16'h3c07, 8'h00);
        check(gotData, 8'h5d);
        check(rdLast, 12);
        slow <= 1'b0;
        do_op(OP_WRITE, 16'h0033, 8'hc9);
        check(wrLast, 12);
        check(mem.mem[8'h33], 8'hc9);
        do_op(OP_READ, 16'h4433, 8'h00);
        check(gotData, 8'hc9);
        check(gotHigh, 8'h44);
    endtask
    task automatic t_ports();
        @(posedge core_clk);
        portPinIn <= 8'h6e;
        portOut <= 8'h93;
        repeat (100) @(posedge core_clk);
        check(portSample, 8'h6e);
        check(portPinOut, 8'h93);
    endtask
    task automatic t_flash();
        resetPin <= 1'b1;
        storePin <= 1'b1;
        repeat (5) @(posedge core_clk);
        check(flashMode, 1'b1);
        progPulsePin <= 1'b1;
        repeat (25) @(posedge core_clk);
        progPulsePin <= 1'b0;
        repeat (10) @(posedge core_clk);
        check(progs, 1);
        check(flashPulseBad, 1'b0);
        progPulsePin <= 1'b1;
        repeat (40) @(posedge core_clk);
        progPulsePin <= 1'b0;
        repeat (10) @(posedge core_clk);
        check(flashPulseBad, 1'b1);
        check(progs, 1);
        latchPin <= 1'b1;
        repeat (5) @(posedge core_clk);
        check(flashMode, 1'b0);
        latchPin <= 1'b0;
        repeat (5) @(posedge core_clk);
        check(flashMode, 1'b1);
        storePin <= 1'b0;
        repeat (5) @(posedge core_clk);
        check(flashMode, 1'b0);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        {rst, reqValid, slow, resetPin, latchPin, storePin, progPulsePin} = 7'h40;
        {portOut, portPinIn} = 16'h0000;
        req = '{op: OP_IDLE, addr: 16'h0000, wdata: 8'h00};
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_fetch();
        t_read_write();
        t_ports();
        t_flash();
        report_and_stop();
    end
endmodule // tb
